// *** hw/iacm_pkg.sv ***
// Purpose: shared constants and operation codes for the integer alu datapath
// Assumes: 32-bit data, 16-bit instruction constants
// Notes: operation codes are this block's own encoding

package iacm_pkg;

  // ****************************************************************
  // widths and timing
  // ****************************************************************
  localparam int IACM_DATA_W = 32;
  localparam int IACM_IMM_W = 16;
  localparam int IACM_OP_W = 6;
  localparam int IACM_DIV_CYCLES = 32;
  localparam logic [31:0] IACM_RESULT_RST = 32'h0000_0000;

  // ****************************************************************
  // operations
  // ****************************************************************
  typedef enum logic [5:0] {
    IACM_OP_AND = 6'h00,
    IACM_OP_OR = 6'h01,
    IACM_OP_XOR = 6'h02,
    IACM_OP_NOR = 6'h03,
    IACM_OP_ANDI = 6'h04,
    IACM_OP_ORI = 6'h05,
    IACM_OP_XORI = 6'h06,
    IACM_OP_ANDHI = 6'h07,
    IACM_OP_ORHI = 6'h08,
    IACM_OP_XORHI = 6'h09,
    IACM_OP_ADD = 6'h0a,
    IACM_OP_SUB = 6'h0b,
    IACM_OP_MUL = 6'h0c,
    IACM_OP_DIV = 6'h0d,
    IACM_OP_DIVU = 6'h0e,
    IACM_OP_ADDI = 6'h0f,
    IACM_OP_SUBI = 6'h10,
    IACM_OP_MULI = 6'h11,
    IACM_OP_MULXSS = 6'h12,
    IACM_OP_MULXUU = 6'h13,
    IACM_OP_MULXSU = 6'h14,
    IACM_OP_MOV = 6'h15,
    IACM_OP_MOVI = 6'h16,
    IACM_OP_MOVUI = 6'h17,
    IACM_OP_MOVHI = 6'h18,
    IACM_OP_CMPEQ = 6'h19,
    IACM_OP_CMPNE = 6'h1a,
    IACM_OP_CMPGE = 6'h1b,
    IACM_OP_CMPGEU = 6'h1c,
    IACM_OP_CMPGT = 6'h1d,
    IACM_OP_CMPGTU = 6'h1e,
    IACM_OP_CMPLE = 6'h1f,
    IACM_OP_CMPLEU = 6'h20,
    IACM_OP_CMPLT = 6'h21,
    IACM_OP_CMPLTU = 6'h22,
    IACM_OP_CMPEQI = 6'h23,
    IACM_OP_CMPNEI = 6'h24,
    IACM_OP_CMPGEI = 6'h25,
    IACM_OP_CMPGEUI = 6'h26,
    IACM_OP_CMPGTI = 6'h27,
    IACM_OP_CMPGTUI = 6'h28,
    IACM_OP_CMPLEI = 6'h29,
    IACM_OP_CMPLEUI = 6'h2a,
    IACM_OP_CMPLTI = 6'h2b,
    IACM_OP_CMPLTUI = 6'h2c
  } iacm_op_t;

  typedef enum logic [2:0] {
    IACM_ST_IDLE = 3'b001,
    IACM_ST_DIV = 3'b010,
    IACM_ST_DONE = 3'b100
  } iacm_state_t;

endpackage

// *** hw/iacm_divider.sv ***
// Purpose: iterative 32-bit restoring divider, signed or unsigned
// Assumes: start pulses only while idle; inputs held by caller not needed
// Notes: divide by zero returns all ones quotient in unsigned terms

`timescale 1ns/10ps
`default_nettype none

module iacm_divider
  import iacm_pkg::*;
#(
  parameter int WIDTH = IACM_DATA_W
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic signed_in,
  input wire logic [WIDTH-1:0] dividend_in,
  input wire logic [WIDTH-1:0] divisor_in,
  output logic done_out,
  output logic [WIDTH-1:0] quotient_out
);

  // ****************************************************************
  // operand magnitudes
  // ****************************************************************
  wire logic neg_a = signed_in & dividend_in[WIDTH-1];
  wire logic neg_b = signed_in & divisor_in[WIDTH-1];
  wire logic [WIDTH-1:0] mag_a = neg_a ? (~dividend_in + 1'b1) : dividend_in;
  wire logic [WIDTH-1:0] mag_b = neg_b ? (~divisor_in + 1'b1) : divisor_in;

  logic [WIDTH-1:0] quo_r;
  logic [WIDTH-1:0] rem_r;
  logic [WIDTH-1:0] dvs_r;
  logic [5:0] cnt_r;
  logic neg_r;
  logic busy_r;

  wire logic [WIDTH:0] trial = {rem_r, quo_r[WIDTH-1]} - {1'b0, dvs_r};
  wire logic fits = ~trial[WIDTH];
  wire logic last = (cnt_r == 6'h01);
  wire logic [WIDTH-1:0] quo_nxt = {quo_r[WIDTH-2:0], fits};
  wire logic [WIDTH-1:0] rem_nxt = fits ? trial[WIDTH-1:0] : {rem_r[WIDTH-2:0], quo_r[WIDTH-1]};

  // ****************************************************************
  // shift and subtract
  // ****************************************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      quo_r <= '0;
      rem_r <= '0;
      dvs_r <= '0;
      cnt_r <= 6'h00;
      neg_r <= 1'b0;
      busy_r <= 1'b0;
      done_out <= 1'b0;
      quotient_out <= '0;
    end else if (ce_in) begin
      done_out <= 1'b0;
      if (start_in && !busy_r) begin
        quo_r <= mag_a;
        rem_r <= '0;
        dvs_r <= mag_b;
        cnt_r <= 6'(IACM_DIV_CYCLES);
        neg_r <= neg_a ^ neg_b;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        quo_r <= quo_nxt;
        rem_r <= rem_nxt;
        cnt_r <= cnt_r - 6'h01;
        if (last) begin
          busy_r <= 1'b0;
          done_out <= 1'b1;
          quotient_out <= neg_r ? (~quo_nxt + 1'b1) : quo_nxt;
        end
      end
    end
  end

endmodule

`default_nettype wire

// *** hw/iacm_alu.sv ***
// Purpose: integer execution datapath: logic, arithmetic, moves, compares
// Assumes: operands and decoded operation arrive valid for one cycle with issue
// Notes: result registered; divide takes an iterative path and stalls issue
//
// Operation
// - register and, or, xor, nor combine two words bit by bit
// - low immediate logic forms zero-extend the 16-bit constant
// - high immediate logic forms place constant in upper half, low zeros
// - add, sub, mul, signed and unsigned divide on two registers
// - immediate add, sub, mul use sign-extended 16-bit constant
// - upper product returns high 32 bits, signed-signed or unsigned-unsigned
// - upper product stands alone, no prior low multiply needed
// - mixed upper product: first operand signed, second unsigned
// - register move copies the source unchanged
// - signed constant move sign-extends 16-bit immediate to 32 bits
// - lower or upper constant move places immediate, other bits zero
// - every compare writes exactly one when true, zero otherwise
// - compares cover eq, ne, signed and unsigned orderings
// - immediate compares use a 16-bit instruction constant
// - signed immediate compares sign-extend the constant
// - unsigned immediate compares zero-fill the constant

`timescale 1ns/10ps
`default_nettype none

module iacm_alu
  import iacm_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic issue_valid_in,
  input wire logic [IACM_OP_W-1:0] op_in,
  input wire logic [IACM_DATA_W-1:0] src_a_in,
  input wire logic [IACM_DATA_W-1:0] src_b_in,
  input wire logic [IACM_IMM_W-1:0] imm_in,
  input wire logic [4:0] dest_in,
  output logic issue_ready_out,
  output logic result_valid_out,
  output logic [IACM_DATA_W-1:0] result_out,
  output logic [4:0] result_dest_out,
  output logic illegal_op_out
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_sync1_r;
  logic rst_n_r;

  // reset asserts at once and leaves on the clock, two flops late
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_sync1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_sync1_r <= 1'b1;
      rst_n_r <= rst_sync1_r;
    end
  end

  // ****************************************************************
  // immediate forms
  // ****************************************************************
  // zero extension, sign extension, upper-half placement
  wire logic [31:0] imm_zext = {16'h0000, imm_in};
  wire logic [31:0] imm_sext = {{16{imm_in[15]}}, imm_in};
  wire logic [31:0] imm_high = {imm_in, 16'h0000};

  iacm_op_t op;
  assign op = iacm_op_t'(op_in);

  // ****************************************************************
  // second operand select
  // ****************************************************************
  // at most one immediate select is high; register operand otherwise
  // unsigned compares zero-fill
  wire logic sel_zext = (op == IACM_OP_ANDI)
    || (op == IACM_OP_ORI)
    || (op == IACM_OP_XORI)
    || (op == IACM_OP_CMPGEUI)
    || (op == IACM_OP_CMPGTUI)
    || (op == IACM_OP_CMPLEUI)
    || (op == IACM_OP_CMPLTUI)
    || (op == IACM_OP_MOVUI);
  wire logic sel_sext = (op == IACM_OP_ADDI)
    || (op == IACM_OP_SUBI)
    || (op == IACM_OP_MULI)
    || (op == IACM_OP_CMPEQI)
    || (op == IACM_OP_CMPNEI)
    || (op == IACM_OP_CMPGEI)
    || (op == IACM_OP_CMPGTI)
    || (op == IACM_OP_CMPLEI)
    || (op == IACM_OP_CMPLTI)
    || (op == IACM_OP_MOVI);
  wire logic sel_high = (op == IACM_OP_ANDHI)
    || (op == IACM_OP_ORHI)
    || (op == IACM_OP_XORHI)
    || (op == IACM_OP_MOVHI);

  wire logic [31:0] opb = sel_zext ? imm_zext
    : sel_sext ? imm_sext
    : sel_high ? imm_high
    : src_b_in;
  wire logic [31:0] opa = src_a_in;

  // ****************************************************************
  // logic and arithmetic
  // ****************************************************************
  // bitwise combine, add and subtract
  wire logic [31:0] and_res = opa & opb;
  wire logic [31:0] or_res = opa | opb;
  wire logic [31:0] xor_res = opa ^ opb;
  wire logic [31:0] nor_res = ~(opa | opb);
  wire logic [31:0] add_res = opa + opb;
  wire logic [31:0] sub_res = opa - opb;

  // each product computed from operands alone
  wire logic [63:0] prod_uu = {32'h0, opa} * {32'h0, opb};
  wire logic [63:0] prod_ss = 64'($signed({{32{opa[31]}}, opa})
    * $signed({{32{opb[31]}}, opb}));
  wire logic [63:0] prod_su = 64'($signed({{32{opa[31]}}, opa})
    * $signed({32'h0, opb}));

  // ****************************************************************
  // comparisons
  // ****************************************************************
  wire logic is_eq = (opa == opb);
  wire logic lt_s = ($signed(opa) < $signed(opb));
  wire logic lt_u = (opa < opb);
  wire logic le_s = lt_s | is_eq;
  wire logic le_u = lt_u | is_eq;

  // ****************************************************************
  // result mux
  // ****************************************************************
  logic [31:0] comb_res;
  logic cmp_true;
  logic is_cmp;
  logic is_div;
  logic is_legal;

  always_comb begin
    comb_res = 32'h0000_0000;
    cmp_true = 1'b0;
    is_cmp = 1'b0;
    is_div = 1'b0;
    is_legal = 1'b1;
    unique case (op)
      IACM_OP_AND, IACM_OP_ANDI, IACM_OP_ANDHI: begin
        comb_res = and_res;
      end
      IACM_OP_OR, IACM_OP_ORI, IACM_OP_ORHI: begin
        comb_res = or_res;
      end
      IACM_OP_XOR, IACM_OP_XORI, IACM_OP_XORHI: begin
        comb_res = xor_res;
      end
      IACM_OP_NOR: begin
        comb_res = nor_res;
      end
      IACM_OP_ADD, IACM_OP_ADDI: begin
        comb_res = add_res;
      end
      IACM_OP_SUB, IACM_OP_SUBI: begin
        comb_res = sub_res;
      end
      IACM_OP_MUL, IACM_OP_MULI: begin
        comb_res = prod_uu[31:0];
      end
      IACM_OP_MULXSS: begin
        comb_res = prod_ss[63:32];
      end
      IACM_OP_MULXUU: begin
        comb_res = prod_uu[63:32];
      end
      IACM_OP_MULXSU: begin
        comb_res = prod_su[63:32];
      end
      IACM_OP_DIV, IACM_OP_DIVU: begin
        is_div = 1'b1;
      end
      IACM_OP_MOV: begin
        comb_res = opa;
      end
      IACM_OP_MOVI, IACM_OP_MOVUI, IACM_OP_MOVHI: begin
        comb_res = opb;
      end
      // immediate compares share the relation logic
      IACM_OP_CMPEQ, IACM_OP_CMPEQI: begin
        is_cmp = 1'b1;
        cmp_true = is_eq;
      end
      IACM_OP_CMPNE, IACM_OP_CMPNEI: begin
        is_cmp = 1'b1;
        cmp_true = ~is_eq;
      end
      IACM_OP_CMPGE, IACM_OP_CMPGEI: begin
        is_cmp = 1'b1;
        cmp_true = ~lt_s;
      end
      IACM_OP_CMPGEU, IACM_OP_CMPGEUI: begin
        is_cmp = 1'b1;
        cmp_true = ~lt_u;
      end
      IACM_OP_CMPGT, IACM_OP_CMPGTI: begin
        is_cmp = 1'b1;
        cmp_true = ~le_s;
      end
      IACM_OP_CMPGTU, IACM_OP_CMPGTUI: begin
        is_cmp = 1'b1;
        cmp_true = ~le_u;
      end
      IACM_OP_CMPLE, IACM_OP_CMPLEI: begin
        is_cmp = 1'b1;
        cmp_true = le_s;
      end
      IACM_OP_CMPLEU, IACM_OP_CMPLEUI: begin
        is_cmp = 1'b1;
        cmp_true = le_u;
      end
      IACM_OP_CMPLT, IACM_OP_CMPLTI: begin
        is_cmp = 1'b1;
        cmp_true = lt_s;
      end
      IACM_OP_CMPLTU, IACM_OP_CMPLTUI: begin
        is_cmp = 1'b1;
        cmp_true = lt_u;
      end
      default: begin
        is_legal = 1'b0;
      end
    endcase
    if (is_cmp) begin
      comb_res = {31'h0, cmp_true};
    end
  end

  // ****************************************************************
  // divide path
  // ****************************************************************
  iacm_state_t state_r;
  iacm_state_t state_nxt;
  logic div_done;
  logic [31:0] div_quo;
  logic [4:0] div_dest_r;

  wire logic idle = (state_r == IACM_ST_IDLE);
  wire logic take = issue_valid_in && idle;
  wire logic div_start = take && is_div;

  // ready stays low through the divide and its writeback cycle
  assign issue_ready_out = idle;

  iacm_divider #(
    .WIDTH(IACM_DATA_W)
  ) u_div (
    .clk_in(ref_clk_in),
    .rst_n_in(rst_n_r),
    .ce_in(ce_in),
    .start_in(div_start),
    .signed_in(op == IACM_OP_DIV),
    .dividend_in(opa),
    .divisor_in(opb),
    .done_out(div_done),
    .quotient_out(div_quo)
  );

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      IACM_ST_IDLE: begin
        if (div_start) begin
          state_nxt = IACM_ST_DIV;
        end
      end
      IACM_ST_DIV: begin
        if (div_done) begin
          state_nxt = IACM_ST_DONE;
        end
      end
      IACM_ST_DONE: begin
        state_nxt = IACM_ST_IDLE;
      end
      default: begin
        state_nxt = IACM_ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // result register
  // ****************************************************************
  always_ff @(posedge ref_clk_in or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= IACM_ST_IDLE;
      result_valid_out <= 1'b0;
      result_out <= IACM_RESULT_RST;
      result_dest_out <= 5'h00;
      illegal_op_out <= 1'b0;
      div_dest_r <= 5'h00;
    end else if (ce_in) begin
      state_r <= state_nxt;
      result_valid_out <= 1'b0;
      illegal_op_out <= 1'b0;
      if (take && !is_div) begin
        result_valid_out <= is_legal;
        illegal_op_out <= ~is_legal;
        result_out <= comb_res;
        result_dest_out <= dest_in;
      end
      if (div_start) begin
        div_dest_r <= dest_in;
      end
      // divide writeback; idle is low, so no issue shares this edge
      if (div_done) begin
        result_valid_out <= 1'b1;
        result_out <= div_quo;
        result_dest_out <= div_dest_r;
      end
    end
  end

endmodule

`default_nettype wire

// *** sim/iacm_alu_props.sv ***
// Purpose: port-level checks on the integer alu datapath
// Assumes: ce_in stays high while a divide runs
// Notes: bound to every iacm_alu instance

`timescale 1ns/10ps
`default_nettype none

module iacm_alu_props
  import iacm_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic issue_valid_in,
  input wire logic [IACM_OP_W-1:0] op_in,
  input wire logic [IACM_DATA_W-1:0] src_a_in,
  input wire logic [IACM_DATA_W-1:0] src_b_in,
  input wire logic [IACM_IMM_W-1:0] imm_in,
  input wire logic [4:0] dest_in,
  input wire logic issue_ready_out,
  input wire logic result_valid_out,
  input wire logic [IACM_DATA_W-1:0] result_out,
  input wire logic [4:0] result_dest_out,
  input wire logic illegal_op_out
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  logic take;
  logic [63:0] mixed;
  logic [31:0] mixed_hi;
  assign take = ce_in && issue_valid_in && issue_ready_out;
  assign mixed = {{32{src_a_in[31]}}, src_a_in} * {32'h0, src_b_in};
  assign mixed_hi = mixed[63:32];

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  // ****************************************************************
  // properties
  // ****************************************************************
  sequence s_div_issue;
    take && (op_in == IACM_OP_DIV || op_in == IACM_OP_DIVU);
  endsequence
  property p_nor;
    take && op_in == IACM_OP_NOR |=> result_out == ~($past(src_a_in) | $past(src_b_in));
  endproperty
  property p_andi;
    take && op_in == IACM_OP_ANDI |=> result_out == ($past(src_a_in) & {16'h0, $past(imm_in)});
  endproperty
  property p_orhi;
    take && op_in == IACM_OP_ORHI |=> result_out == ($past(src_a_in) | {$past(imm_in), 16'h0});
  endproperty
  property p_sub;
    take && op_in == IACM_OP_SUB |=> result_valid_out && result_out == $past(src_a_in) - $past(src_b_in);
  endproperty
  property p_mulxsu;
    take && op_in == IACM_OP_MULXSU |=> result_out == $past(mixed_hi);
  endproperty
  property p_movi;
    take && op_in == IACM_OP_MOVI |=> result_out[31:15] == {17{$past(imm_in[15])}};
  endproperty
  property p_cmple;
    take && op_in == IACM_OP_CMPLE |=>
      result_out == {31'h0, $signed($past(src_a_in)) <= $signed($past(src_b_in))};
  endproperty
  property p_cmp_one;
    take && op_in >= IACM_OP_CMPEQ && op_in <= IACM_OP_CMPLTUI |=>
      result_valid_out && result_out[31:1] == 31'h0 && result_dest_out == $past(dest_in);
  endproperty
  property p_illegal;
    take && op_in > IACM_OP_CMPLTUI |=> illegal_op_out && !result_valid_out;
  endproperty
  property p_div_busy;
    s_div_issue |=> !issue_ready_out [*8];
  endproperty
  property p_div_time;
    s_div_issue |-> ##34 result_valid_out;
  endproperty

  a_nor: assert property (p_nor) else $error("nor result wrong");
  a_andi: assert property (p_andi) else $error("andi result wrong");
  a_orhi: assert property (p_orhi) else $error("orhi result wrong");
  a_sub: assert property (p_sub) else $error("sub result wrong");
  a_mulxsu: assert property (p_mulxsu) else $error("mixed upper product wrong");
  a_movi: assert property (p_movi) else $error("movi not sign extended");
  a_cmple: assert property (p_cmple) else $error("cmple not signed");
  a_cmp_one: assert property (p_cmp_one) else $error("compare not one or zero");
  a_illegal: assert property (p_illegal) else $error("illegal op not flagged");
  a_div_busy: assert property (p_div_busy) else $error("ready during divide");
  a_div_time: assert property (p_div_time) else $error("divide result late");
endmodule

bind iacm_alu iacm_alu_props i_props (
  .ref_clk_in, .rstn_in, .ce_in, .issue_valid_in, .op_in, .src_a_in, .src_b_in,
  .imm_in, .dest_in, .issue_ready_out, .result_valid_out, .result_out,
  .result_dest_out, .illegal_op_out
);

`default_nettype wire

// *** sim/iacm_rf_model.sv ***
// Purpose: general register file seen from the writeback side
// Assumes: one write per cycle from the datapath result
// Notes: read port is combinational

`timescale 1ns/10ps
`default_nettype none

module iacm_rf_model (
  input wire logic clk_in,
  input wire logic wr_en_in,
  input wire logic [4:0] wr_addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic [4:0] rd_addr_in,
  output logic [31:0] rd_data_out
);
  logic [31:0] regs_r [32];
  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      regs_r[wr_addr_in] <= wr_data_in;
    end
  end
  assign rd_data_out = regs_r[rd_addr_in];
endmodule

`default_nettype wire

// *** sim/iacm_alu_tb.sv ***
// Purpose: self-checking bench for the integer alu datapath
// Assumes: inputs driven on the falling edge
// Notes: register file model takes every result

`timescale 1ns/10ps
`default_nettype none

module iacm_alu_tb;
  import iacm_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic ce_in = 1'b1;
  logic issue_valid_in = 1'b0;
  logic [5:0] op_in = 6'h00;
  logic [31:0] src_a_in = 32'h0;
  logic [31:0] src_b_in = 32'h0;
  logic [15:0] imm_in = 16'h0;
  logic [4:0] dest_in = 5'h0;
  logic issue_ready_out;
  logic result_valid_out;
  logic [31:0] result_out;
  logic [4:0] result_dest_out;
  logic illegal_op_out;
  logic [31:0] rf_data;
  int checks = 0;
  int err_total = 0;
  int cycles = 0;
  localparam logic [31:0] A = 32'h8000_0003;
  localparam logic [31:0] B = 32'h0000_0005;
  localparam logic [15:0] K = 16'h8001;
  localparam logic [31:0] KS = 32'hffff_8001;

  always #20 ref_clk_in = ~ref_clk_in;

  iacm_alu i_dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .issue_valid_in(issue_valid_in), .op_in(op_in), .src_a_in(src_a_in),
    .src_b_in(src_b_in), .imm_in(imm_in), .dest_in(dest_in),
    .issue_ready_out(issue_ready_out), .result_valid_out(result_valid_out),
    .result_out(result_out), .result_dest_out(result_dest_out),
    .illegal_op_out(illegal_op_out));
  iacm_rf_model i_rf (.clk_in(ref_clk_in), .wr_en_in(result_valid_out),
    .wr_addr_in(result_dest_out), .wr_data_in(result_out),
    .rd_addr_in(result_dest_out), .rd_data_out(rf_data));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      complete_run();
    end
  end

  // one issue cycle, result looked at on the falling edge after the taking edge
  task automatic do_op(input logic [5:0] op, input logic [31:0] a, input logic [31:0] b,
    input logic [15:0] k, input logic [31:0] exp);
    @(negedge ref_clk_in);
    op_in = op;
    src_a_in = a;
    src_b_in = b;
    imm_in = k;
    dest_in = dest_in + 5'h1;
    issue_valid_in = 1'b1;
    @(negedge ref_clk_in);
    issue_valid_in = 1'b0;
    check($sformatf("valid op %h", op), {31'h0, result_valid_out}, 32'h1);
    check($sformatf("result op %h", op), result_out, exp);
    check($sformatf("dest op %h", op), {27'h0, result_dest_out}, {27'h0, dest_in});
  endtask

  function automatic logic [31:0] hi(input logic sa, input logic sb,
    input logic [31:0] a, input logic [31:0] b);
    logic [63:0] p;
    p = {{32{sa & a[31]}}, a} * {{32{sb & b[31]}}, b};
    return p[63:32];
  endfunction

  function automatic logic [31:0] cmp_exp(input logic [5:0] op, input logic [31:0] a,
    input logic [31:0] r, input logic [15:0] k);
    logic [31:0] s;
    logic [31:0] u;
    logic t;
    s = {{16{k[15]}}, k};
    u = {16'h0, k};
    case (op)
      IACM_OP_CMPEQ: t = a == r;
      IACM_OP_CMPNE: t = a != r;
      IACM_OP_CMPGE: t = $signed(a) >= $signed(r);
      IACM_OP_CMPGEU: t = a >= r;
      IACM_OP_CMPGT: t = $signed(a) > $signed(r);
      IACM_OP_CMPGTU: t = a > r;
      IACM_OP_CMPLE: t = $signed(a) <= $signed(r);
      IACM_OP_CMPLEU: t = a <= r;
      IACM_OP_CMPLT: t = $signed(a) < $signed(r);
      IACM_OP_CMPLTU: t = a < r;
      IACM_OP_CMPEQI: t = a == s;
      IACM_OP_CMPNEI: t = a != s;
      IACM_OP_CMPGEI: t = $signed(a) >= $signed(s);
      IACM_OP_CMPGEUI: t = a >= u;
      IACM_OP_CMPGTI: t = $signed(a) > $signed(s);
      IACM_OP_CMPGTUI: t = a > u;
      IACM_OP_CMPLEI: t = $signed(a) <= $signed(s);
      IACM_OP_CMPLEUI: t = a <= u;
      IACM_OP_CMPLTI: t = $signed(a) < $signed(s);
      default: t = a < u;
    endcase
    return {31'h0, t};
  endfunction

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_mulx();
    do_op(IACM_OP_MULXSS, A, KS, 16'h0, hi(1'b1, 1'b1, A, KS));
    do_op(IACM_OP_MULXUU, A, KS, 16'h0, hi(1'b0, 1'b0, A, KS));
    do_op(IACM_OP_MULXSU, A, KS, 16'h0, hi(1'b1, 1'b0, A, KS));
  endtask

  task automatic t_logic();
    do_op(IACM_OP_AND, A, KS, 16'h0, A & KS);
    do_op(IACM_OP_OR, A, B, 16'h0, A | B);
    do_op(IACM_OP_XOR, A, KS, 16'h0, A ^ KS);
    do_op(IACM_OP_NOR, A, B, 16'h0, ~(A | B));
    do_op(IACM_OP_ANDI, KS, B, K, KS & 32'h0000_8001);
    do_op(IACM_OP_ORI, A, B, K, A | 32'h0000_8001);
    do_op(IACM_OP_XORI, KS, B, K, KS ^ 32'h0000_8001);
    do_op(IACM_OP_ANDHI, KS, B, K, KS & 32'h8001_0000);
    do_op(IACM_OP_ORHI, B, A, K, B | 32'h8001_0000);
    do_op(IACM_OP_XORHI, KS, B, K, KS ^ 32'h8001_0000);
  endtask

  task automatic t_arith();
    do_op(IACM_OP_ADD, A, KS, 16'h0, A + KS);
    do_op(IACM_OP_SUB, B, A, 16'h0, B - A);
    do_op(IACM_OP_MUL, A, KS, 16'h0, A * KS);
    do_op(IACM_OP_ADDI, B, A, K, B + KS);
    do_op(IACM_OP_SUBI, B, A, K, B - KS);
    do_op(IACM_OP_MULI, A, B, K, A * KS);
  endtask

  task automatic t_move();
    do_op(IACM_OP_MOV, A, B, K, A);
    do_op(IACM_OP_MOVI, B, A, K, KS);
    do_op(IACM_OP_MOVUI, A, B, K, 32'h0000_8001);
    do_op(IACM_OP_MOVHI, A, B, K, 32'h8001_0000);
    // address built from upper move and low or
    @(negedge ref_clk_in);
    do_op(IACM_OP_ORI, rf_data, B, 16'habcd, 32'h8001_abcd);
    @(negedge ref_clk_in);
    check("address in register file", rf_data, 32'h8001_abcd);
  endtask

  task automatic t_cmp();
    for (int p = 0; p < 3; p++) begin
      for (int o = IACM_OP_CMPEQ; o <= IACM_OP_CMPLTUI; o++) begin
        do_op(6'(o), p == 0 ? A : B, p == 2 ? A : B, p == 1 ? 16'h0005 : K,
          cmp_exp(6'(o), p == 0 ? A : B, p == 2 ? A : B, p == 1 ? 16'h0005 : K));
      end
    end
  endtask

  task automatic t_div(input logic [5:0] op, input logic [31:0] exp);
    int n = 0;
    @(negedge ref_clk_in);
    op_in = op;
    src_a_in = A;
    src_b_in = B;
    dest_in = dest_in + 5'h1;
    issue_valid_in = 1'b1;
    @(negedge ref_clk_in);
    issue_valid_in = 1'b0;
    check("ready in divide", {31'h0, issue_ready_out}, 32'h0);
    while (n < 40 && result_valid_out !== 1'b1) begin
      @(negedge ref_clk_in);
      n++;
    end
    check("divide cycles", 32'(n), 32'(IACM_DIV_CYCLES + 1));
    check("quotient", result_out, exp);
    check("divide dest", {27'h0, result_dest_out}, {27'h0, dest_in});
    for (int i = 0; i < 5 && issue_ready_out !== 1'b1; i++) begin
      @(negedge ref_clk_in);
    end
  endtask

  task automatic t_misc();
    @(negedge ref_clk_in);
    op_in = IACM_OP_ADD;
    ce_in = 1'b0;
    issue_valid_in = 1'b1;
    @(negedge ref_clk_in);
    check("frozen valid", {31'h0, result_valid_out}, 32'h0);
    ce_in = 1'b1;
    op_in = 6'h3f;
    @(negedge ref_clk_in);
    issue_valid_in = 1'b0;
    check("illegal flag", {31'h0, illegal_op_out}, 32'h1);
    check("illegal valid", {31'h0, result_valid_out}, 32'h0);
  endtask

  initial begin
    repeat (20) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    rstn_in = 1'b1;
    repeat (3) @(negedge ref_clk_in);
    t_mulx();
    t_logic();
    t_arith();
    t_move();
    t_cmp();
    t_div(IACM_OP_DIV, 32'($signed(A) / $signed(B)));
    t_div(IACM_OP_DIVU, A / B);
    t_misc();
    complete_run();
  end
endmodule

`default_nettype wire
